// [hw/plsv_pkg.sv]
`default_nettype none
package plsv_pkg;
  // Register byte offsets on the APB window
  localparam logic [7:0] A_HEALTH = 8'h00;
  localparam logic [7:0] A_RST_DLY = 8'h04;
  localparam logic [7:0] A_ALM_CNT = 8'h08;
  localparam logic [7:0] A_WRN_CNT = 8'h0c;
  localparam logic [7:0] A_T_ALM = 8'h10;
  localparam logic [7:0] A_T_WRN = 8'h14;
  localparam logic [7:0] A_LATENCY = 8'h18;
  localparam logic [7:0] A_PROP = 8'h1c;
  localparam logic [7:0] A_RTT = 8'h20;
  localparam logic [7:0] A_RBIN = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  // Link health codes as read by software
  localparam logic [31:0] H_OK = 32'h1;
  localparam logic [31:0] H_WARN = 32'h2;
  localparam logic [31:0] H_ALARM = 32'h3;
  localparam logic [31:0] H_WAIT = 32'hffff_fffe;
  // Field widths
  localparam int CNT_W = 17;
  localparam int DIV_W = 17;
  localparam int MS_W = 19;
  localparam int BIN_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 17'h1869f;
  localparam logic [MS_W-1:0] RST_DLY_DEF = 19'h3e8;
  // Timing: clock rate, telegram period, warning timer
  localparam int CLK_HZ = 20_000_000;
  localparam int TELE_PERIOD_US = 2500;
  localparam int TELE_CYC = TELE_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int GAP_CYC = (TELE_CYC * 3) / 2;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int WARN_TIME_S = 5;
  localparam logic [MS_W-1:0] WARN_MS = MS_W'(WARN_TIME_S * 1000);
  localparam logic [31:0] SEND_LAT_CYC = 32'h1;
  typedef enum logic [1:0] {
    S_WAIT = 2'b00,
    S_OK = 2'b01,
    S_WARN = 2'b11,
    S_ALARM = 2'b10
  } plsv_state_t;
endpackage : plsv_pkg
`default_nettype wire

// [hw/plsv_cnt_if.sv]
`default_nettype none
interface plsv_cnt_if;
  import plsv_pkg::*;
  logic load;
  logic [CNT_W-1:0] loadVal;
  logic inc;
  logic [CNT_W-1:0] count;
  logic [31:0] stamp;
  modport cnt (input load, loadVal, inc, output count, stamp);
  modport ctl (output load, loadVal, inc, input count, stamp);
endinterface : plsv_cnt_if
`default_nettype wire

// [hw/plsv_tick_div.sv]
`default_nettype none
module plsv_tick_div
  import plsv_pkg::*;
#(
  parameter int unsigned DIV = MS_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  output logic tick
);
  logic [DIV_W-1:0] cnt;
  wire atEnd = (cnt == DIV_W'(DIV - 1));

  // Free divider, one-cycle enable at wrap
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= atEnd ? '0 : cnt + 1'b1;
      tick <= atEnd;
    end
  end
endmodule : plsv_tick_div
`default_nettype wire

// [hw/plsv_event_cnt.sv]
`default_nettype none
module plsv_event_cnt
  import plsv_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [31:0] now,
  plsv_cnt_if.cnt c
);
  // Load then count, so an event in the write cycle is kept
  wire [CNT_W-1:0] base = c.load ? ((c.loadVal > CNT_MAX) ? CNT_MAX : c.loadVal) : c.count;
  wire [CNT_W-1:0] next_count = (c.inc && base != CNT_MAX) ? base + 1'b1 : base;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      c.count <= '0;
      c.stamp <= '0;
    end else begin
      c.count <= next_count;
      if (next_count != c.count) c.stamp <= now;
    end
  end

  chk_count_sat: assert property (@(posedge clock) disable iff (!rst_b)
    c.count <= CNT_MAX) else $error("event count above limit");
endmodule : plsv_event_cnt
`default_nettype wire

// [hw/plsv_link_supervisor.sv]
// Overview of operation
// - Missing or late telegram flags interference
// - Short interference enters warning and blocks
// - Block within two network periods of loss
// - Warning persisting five seconds becomes alarm
// - Exchange quality status; apply peer's status
// - Return to ok after programmable clean time
// - Link present while telegrams arrive correctly
// - Ok, warning, alarm outputs are one-hot outside waiting, all low while waiting
// - Latest sample latency readable as data
// - Waiting state until remote starts sending
// - Send one telegram every 2.5 ms
// - Symmetric link, both ends send samples
// - Propagation delay is half the round sum
// - Latency adds local and remote hold delays
// - Count writes load the event counters
// - Valid telegram refreshes remote binary copy
// - Time reference from echo, no clock sync
// - Health read as 1, 2, 3 or -2
// - Saturating counts with change timestamps
`default_nettype none
module plsv_link_supervisor
  import plsv_pkg::*;
#(
  parameter int unsigned TELE_DIV = TELE_CYC,
  parameter int unsigned GAP_LIMIT = GAP_CYC,
  parameter int unsigned MS_DIV = MS_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxStrobe,
  input wire logic rxCrcOk,
  input wire logic rxRemoteBad,
  input wire logic [31:0] rxEchoHold,
  input wire logic [31:0] rxSampleToSend,
  input wire logic [BIN_W-1:0] rxBinary,
  output logic txSend,
  output logic txQualityBad,
  output logic [31:0] txEchoHold,
  output logic [31:0] txSampleToSend,
  output logic okOut,
  output logic warnOut,
  output logic alarmOut,
  output logic linkPresent,
  output logic diffBlock,
  output logic [BIN_W-1:0] remoteBinary
);
  plsv_state_t state, next_state;
  logic [31:0] nowTime, lastTxTime, lastRxTime, lastTickTime;
  logic [31:0] rttDly, propDly, latency;
  logic [DIV_W:0] gapCnt;
  logic [MS_W-1:0] rstDly, cleanMs, warnMs;
  logic remoteBad, seenGood, teleTick, msTick;
  plsv_cnt_if almIf();
  plsv_cnt_if wrnIf();

  // Telegram rate and millisecond base
  plsv_tick_div #(.DIV(TELE_DIV)) teleDiv (
    .clock(clock),
    .rst_b(rst_b),
    .tick(teleTick)
  );
  plsv_tick_div #(.DIV(MS_DIV)) msDiv (
    .clock(clock),
    .rst_b(rst_b),
    .tick(msTick)
  );

  // Receive qualification and interference sources
  wire goodRx = rxStrobe & rxCrcOk;
  wire badRx = rxStrobe & ~rxCrcOk;
  wire gap = (gapCnt >= (DIV_W + 1)'(GAP_LIMIT));
  wire interf = gap | badRx | remoteBad;
  wire cleanDone = (cleanMs >= rstDly);
  wire warnDone = (warnMs >= WARN_MS);

  // Echo timing: round trip less the peer's hold, halved
  wire [31:0] rttNow = (nowTime - lastTxTime) - rxEchoHold;
  wire [31:0] propNow = {1'b0, rttNow[31:1]};
  wire [31:0] rxToSample = lastTickTime + 32'(TELE_DIV) - nowTime;
  wire [31:0] latNow = propNow + rxSampleToSend + rxToSample;

  // Free time base shared by every stamp
  always_ff @(posedge clock) begin
    if (!rst_b) nowTime <= '0;
    else nowTime <= nowTime + 1'b1;
  end

  // Outgoing telegram: sampled at the tick, sent next cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      txSend <= 1'b0;
      lastTickTime <= '0;
      lastTxTime <= '0;
      txEchoHold <= '0;
      txSampleToSend <= '0;
      txQualityBad <= 1'b1;
    end else begin
      txSend <= teleTick;
      if (teleTick) begin
        lastTickTime <= nowTime;
        lastTxTime <= nowTime + SEND_LAT_CYC;
        txEchoHold <= nowTime + SEND_LAT_CYC - lastRxTime;
        txSampleToSend <= SEND_LAT_CYC;
        txQualityBad <= (state != S_OK);
      end
    end
  end

  // Gap watchdog; saturates so a dead link stays flagged
  always_ff @(posedge clock) begin
    if (!rst_b) gapCnt <= '0;
    else if (goodRx) gapCnt <= '0;
    else if (!gap) gapCnt <= gapCnt + 1'b1;
  end

  // Per-telegram measurement and remote copies
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      lastRxTime <= '0;
      rttDly <= '0;
      propDly <= '0;
      latency <= '0;
      remoteBinary <= '0;
      remoteBad <= 1'b0;
      seenGood <= 1'b0;
    end else if (goodRx) begin
      lastRxTime <= nowTime;
      rttDly <= rttNow;
      propDly <= propNow;
      latency <= latNow;
      remoteBinary <= rxBinary;
      remoteBad <= rxRemoteBad;
      seenGood <= 1'b1;
    end
  end

  // Clean-time and warning timers in millisecond steps
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cleanMs <= '0;
      warnMs <= '0;
    end else begin
      if (interf) cleanMs <= '0;
      else if (msTick && !cleanDone) cleanMs <= cleanMs + 1'b1;
      if (state != S_WARN) warnMs <= '0;
      else if (msTick && !warnDone) warnMs <= warnMs + 1'b1;
    end
  end

  // Supervision state machine
  always_comb begin
    next_state = state;
    case (state)
      S_WAIT: if (goodRx && !rxRemoteBad) next_state = S_OK;
      S_OK: if (interf) next_state = S_WARN;
      S_WARN: begin
        if (cleanDone) next_state = S_OK;
        else if (warnDone && interf) next_state = S_ALARM;
      end
      S_ALARM: if (cleanDone) next_state = S_OK;
      default: next_state = S_WAIT;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) state <= S_WAIT;
    else state <= next_state;
  end

  // Registered one-hot outputs and block, waiting blocks too
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      okOut <= 1'b0;
      warnOut <= 1'b0;
      alarmOut <= 1'b0;
      diffBlock <= 1'b1;
      linkPresent <= 1'b0;
    end else begin
      okOut <= (next_state == S_OK);
      warnOut <= (next_state == S_WARN);
      alarmOut <= (next_state == S_ALARM);
      diffBlock <= (next_state != S_OK);
      linkPresent <= (seenGood | goodRx) & ~(gap & ~goodRx) & ~badRx;
    end
  end

  // APB decode; zero wait states, data latched in setup
  wire setup = psel & ~penable;
  wire wrEn = psel & penable & pwrite;
  wire hit = (paddr <= A_STATUS) && (paddr[1:0] == 2'b00);
  wire [31:0] health = (state == S_OK) ? H_OK : (state == S_WARN) ? H_WARN :
                       (state == S_ALARM) ? H_ALARM : H_WAIT;
  wire [31:0] rdMux =
    (paddr == A_HEALTH) ? health :
    (paddr == A_RST_DLY) ? 32'(rstDly) :
    (paddr == A_ALM_CNT) ? 32'(almIf.count) :
    (paddr == A_WRN_CNT) ? 32'(wrnIf.count) :
    (paddr == A_T_ALM) ? almIf.stamp :
    (paddr == A_T_WRN) ? wrnIf.stamp :
    (paddr == A_LATENCY) ? latency :
    (paddr == A_PROP) ? propDly :
    (paddr == A_RTT) ? rttDly :
    (paddr == A_RBIN) ? 32'(remoteBinary) :
    (paddr == A_STATUS) ? {27'h0, seenGood, remoteBad, gap, linkPresent, diffBlock} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prdata <= '0;
      rstDly <= RST_DLY_DEF;
    end else begin
      if (setup) prdata <= rdMux;
      if (wrEn && paddr == A_RST_DLY) rstDly <= pwdata[MS_W-1:0];
    end
  end

  // Event counters: load on write, count on entry
  assign almIf.load = wrEn && (paddr == A_ALM_CNT);
  assign almIf.loadVal = pwdata[CNT_W-1:0];
  assign almIf.inc = (state != S_ALARM) && (next_state == S_ALARM);
  assign wrnIf.load = wrEn && (paddr == A_WRN_CNT);
  assign wrnIf.loadVal = pwdata[CNT_W-1:0];
  assign wrnIf.inc = (state != S_WARN) && (next_state == S_WARN);

  plsv_event_cnt almCnt (
    .clock(clock),
    .rst_b(rst_b),
    .now(nowTime),
    .c(almIf.cnt)
  );
  plsv_event_cnt wrnCnt (
    .clock(clock),
    .rst_b(rst_b),
    .now(nowTime),
    .c(wrnIf.cnt)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_onehot_out: assert property ($past(rst_b) |->
    ((state == S_WAIT) ? ({okOut, warnOut, alarmOut} == 3'b000)
                       : $onehot({okOut, warnOut, alarmOut})))
    else $error("status outputs not one-hot");
  chk_gap_interf: assert property (gap |-> interf)
    else $error("gap not flagged");
  chk_warn_entry: assert property ((state == S_OK && interf) |=>
    (state == S_WARN && diffBlock)) else $error("no warning on interference");
  chk_block_fast: assert property ((state == S_OK && gapCnt == (DIV_W + 1)'(GAP_LIMIT - 1)
    && !goodRx) |-> ##[1:2] diffBlock) else $error("block too late");
  chk_alarm_early: assert property ((state == S_WARN && !warnDone) |=>
    state != S_ALARM) else $error("alarm before five seconds");
  chk_release_time: assert property ((state != S_OK && state != S_WAIT &&
    next_state == S_OK) |-> cleanMs >= rstDly) else $error("released too early");
  chk_remote_apply: assert property ((goodRx && rxRemoteBad && state == S_OK) |->
    ##[1:2] state == S_WARN) else $error("peer status ignored");
  chk_prop_half: assert property (goodRx |=> propDly == {1'b0, rttDly[31:1]})
    else $error("propagation delay not half");
  chk_bin_copy: assert property (goodRx |=> remoteBinary == $past(rxBinary))
    else $error("remote binary not refreshed");
  chk_link_flag: assert property (goodRx |=> linkPresent)
    else $error("link present missing");
  chk_warn_count: assert property ((wrnIf.inc && !wrnIf.load && wrnIf.count < CNT_MAX) |=>
    wrnIf.count == $past(wrnIf.count) + 1'b1) else $error("warning not counted");

  // Loss of the stream must drop link present at once
  chk_link_drop: assert property ((gap && !goodRx) |=> !linkPresent)
    else $error("link present kept on gap");
  // Peer sees our quality as sampled at the telegram tick
  chk_tx_quality: assert property (teleTick |=> txQualityBad == $past(state != S_OK))
    else $error("quality status not sent");
  // Block follows the state, so waiting keeps it raised
  chk_block_state: assert property ($past(rst_b) |-> diffBlock == (state != S_OK))
    else $error("block out of step with state");
  // One telegram per divider wrap, never two in a row
  chk_tx_single: assert property (txSend |=> !txSend)
    else $error("telegram sent twice");

  cov_warn: cover property (state == S_OK ##1 state == S_WARN);
  cov_alarm: cover property (state == S_WARN ##1 state == S_ALARM);
  cov_recover: cover property (state == S_ALARM ##1 state == S_OK);
  cov_start: cover property (state == S_WAIT ##1 state == S_OK);
endmodule : plsv_link_supervisor
`default_nettype wire

// [verification/plsv_peer.sv]
`default_nettype none
module plsv_peer #(
  parameter int LINK = 10,
  parameter int HOLD = 5
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic txSend,
  input wire logic peerOn,
  input wire logic crcBad,
  input wire logic badStat,
  input wire logic [7:0] binVal,
  output logic rxStrobe,
  output logic rxCrcOk,
  output logic rxRemoteBad,
  output logic [31:0] rxEchoHold,
  output logic [31:0] rxSampleToSend,
  output logic [7:0] rxBinary
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  int cnt = 0;
  initial begin
    rxStrobe = 1'b0;
    rxCrcOk = 1'b0;
    rxRemoteBad = 1'b0;
    rxEchoHold = '0;
    rxSampleToSend = '0;
    rxBinary = '0;
  end
  // Answer each telegram after link out, hold, link back; same period both ways
  always @(posedge clock) begin
    rxStrobe <= 1'b0;
    // Fields carry junk between telegrams so stale values never look valid
    rxCrcOk <= ~rxCrcOk;
    rxRemoteBad <= ~rxRemoteBad;
    rxEchoHold <= ~rxEchoHold;
    rxSampleToSend <= ~rxSampleToSend;
    rxBinary <= ~rxBinary;
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (txSend && peerOn) begin
      busy <= 1'b1;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt + 1;
      if (cnt == 2 * LINK + HOLD - 1) begin
        busy <= 1'b0;
        rxStrobe <= 1'b1;
        rxCrcOk <= !crcBad;
        rxRemoteBad <= badStat;
        rxEchoHold <= 32'(HOLD);
        rxSampleToSend <= 32'h3;
        rxBinary <= binVal;
      end
    end
  end
endmodule : plsv_peer
`default_nettype wire

// [verification/tb.sv]
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb
  import plsv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LINK = 10;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q, txEchoHold, txSampleToSend, rxEchoHold, rxSampleToSend;
  logic pready, pslverr, qErr, txSend, txQualityBad, okOut, warnOut, alarmOut;
  logic linkPresent, diffBlock, rxStrobe, rxCrcOk, rxRemoteBad;
  logic [7:0] remoteBinary, rxBinary;
  logic peerOn = 1'b0;
  logic crcBad = 1'b0;
  logic badStat = 1'b0;
  logic [7:0] binVal = 8'h5a;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Shortened telegram period, gap limit and millisecond unit
  plsv_link_supervisor #(.TELE_DIV(200), .GAP_LIMIT(300), .MS_DIV(4)) dut (.clock(clock),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxStrobe(rxStrobe), .rxCrcOk(rxCrcOk), .rxRemoteBad(rxRemoteBad),
    .rxEchoHold(rxEchoHold), .rxSampleToSend(rxSampleToSend), .rxBinary(rxBinary),
    .txSend(txSend), .txQualityBad(txQualityBad), .txEchoHold(txEchoHold),
    .txSampleToSend(txSampleToSend), .okOut(okOut), .warnOut(warnOut),
    .alarmOut(alarmOut), .linkPresent(linkPresent), .diffBlock(diffBlock),
    .remoteBinary(remoteBinary));
  plsv_peer #(.LINK(LINK), .HOLD(5)) peer (.clock(clock), .rst_b(rst_b), .txSend(txSend),
    .peerOn(peerOn), .crcBad(crcBad), .badStat(badStat), .binVal(binVal),
    .rxStrobe(rxStrobe), .rxCrcOk(rxCrcOk), .rxRemoteBad(rxRemoteBad),
    .rxEchoHold(rxEchoHold), .rxSampleToSend(rxSampleToSend), .rxBinary(rxBinary));
  always #25 clock = ~clock;
  // Hang guard, well above the alarm run of about 21000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // One APB transfer; idles a cycle after so strobes never toggle in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    qErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // Poll health until it matches, then check the one-hot outputs and block
  task automatic check_state(input logic [31:0] h, input int n);
    logic [3:0] want;
    want = (h == H_OK) ? 4'b1000 : (h == H_WARN) ? 4'b0101 :
      (h == H_ALARM) ? 4'b0011 : 4'b0001;
    apb(1'b0, A_HEALTH, '0);
    for (int i = 0; i < n && q !== h; i += 3) apb(1'b0, A_HEALTH, '0);
    `CHK(q, h)
    `CHK({okOut, warnOut, alarmOut, diffBlock}, want)
  endtask : check_state
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, '0);
    `CHK(q, want)
  endtask : rd_chk
  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    check_state(H_WAIT, 0);
    rd_chk(A_RST_DLY, 32'(RST_DLY_DEF));
    rd_chk(A_ALM_CNT, 32'h0);
    rd_chk(8'h40, 32'h0);
    `CHK(qErr, 1'b1)
    // Health is read-only, so this write must leave waiting in place
    apb(1'b1, A_HEALTH, H_OK);
    check_state(H_WAIT, 0);
    apb(1'b1, A_RST_DLY, 32'h14);
    apb(1'b1, A_WRN_CNT, 32'h7);
    rd_chk(A_WRN_CNT, 32'h7);
    peerOn <= 1'b1;
    check_state(H_OK, 2000);
    `CHK(linkPresent, 1'b1)
    `CHK(remoteBinary, 8'h5a)
    apb(1'b0, A_PROP, '0);
    `CHK(q >= LINK - 1 && q <= LINK + 1, 1'b1)
    apb(1'b0, A_LATENCY, '0);
    `CHK(q >= LINK + 2 && q <= LINK + 204, 1'b1)
    apb(1'b0, A_RTT, '0);
    `CHK(q >= 2 * LINK && q <= 2 * LINK + 3, 1'b1)
    badStat <= 1'b1;
    check_state(H_WARN, 1000);
    rd_chk(A_WRN_CNT, 32'h8);
    apb(1'b0, A_T_WRN, '0);
    `CHK(q != 32'h0, 1'b1)
    badStat <= 1'b0;
    check_state(H_OK, 1000);
    crcBad <= 1'b1;
    check_state(H_WARN, 1000);
    crcBad <= 1'b0;
    check_state(H_OK, 1000);
    apb(1'b1, A_ALM_CNT, 32'(CNT_MAX));
    peerOn <= 1'b0;
    check_state(H_WARN, 520);
    check_state(H_ALARM, 21000);
    rd_chk(A_ALM_CNT, 32'(CNT_MAX));
    `CHK(txQualityBad, 1'b1)
    peerOn <= 1'b1;
    check_state(H_OK, 2000);
    end_sim();
  end
endmodule : tb
`default_nettype wire
